// file: pkg/cisc_consts.svh
// timing and register constants for the card interface supervisor
`ifndef CISC_CONSTS_SVH
`define CISC_CONSTS_SVH
`define CISC_CLK_MHZ 20
`define CISC_T_VCC_VPP_US 16
`define CISC_T_VPP_CLK_US 64
`define CISC_T_DEACT_STEP_US 30
`define CISC_CYC_VCC_VPP (`CISC_T_VCC_VPP_US * `CISC_CLK_MHZ)
`define CISC_CYC_VPP_CLK (`CISC_T_VPP_CLK_US * `CISC_CLK_MHZ)
`define CISC_CYC_DEACT (`CISC_T_DEACT_STEP_US * `CISC_CLK_MHZ)
`define CISC_CNT_W 12
`define CISC_ADDR_CTRL 4'h0
`define CISC_ADDR_STAT 4'h4
`define CISC_CTRL_RST 4'h0
`define CISC_BAD_DATA 32'hDEAD_0BAD
`endif

// file: pkg/cisc_pkg.sv
// types shared by the card interface supervisor
package cisc_pkg;
	typedef enum logic [2:0] {
		MODE_IDLE,
		MODE_ACT,
		MODE_READ,
		MODE_WRITE,
		MODE_DEACT,
		MODE_FAULT
	} cisc_mode_t;
	typedef enum logic [2:0] {
		SEQ_OFF,
		SEQ_VCC,
		SEQ_VPP,
		SEQ_CLK,
		SEQ_D_CLK,
		SEQ_D_VPP
	} cisc_seq_t;
endpackage : cisc_pkg

// file: rtl/cisc_clkgen.sv
// card and host clock dividers with glitch-free ratio change
`timescale 1ns/1ps
module cisc_clkgen (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic clk_half_sel_n,
	input wire logic clk_quarter_sel_n,
	input wire logic internal_reset_enable,
	output logic host_half_clock,
	output logic card_clk
);
	logic half_q;
	logic quarter_q;
	logic sel_half_q;
	logic sel_quarter_q;
	logic run_q;
	logic out_q;
	logic want_half;
	logic want_quarter;
	logic want_run;
	logic boundary;

	// first stage always halves the input clock
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			half_q <= 1'b0;
			quarter_q <= 1'b0;
		end else begin
			half_q <= ~half_q;
			if (half_q)
				quarter_q <= ~quarter_q;
		end
	end

	assign want_half = ~clk_half_sel_n;
	assign want_quarter = clk_half_sel_n & ~clk_quarter_sel_n;
	assign want_run = internal_reset_enable & (want_half | want_quarter);
	// change ratio only where both dividers are high, so no runt pulse
	assign boundary = half_q & quarter_q;

	// selection is sampled at the boundary where both dividers are high
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			sel_half_q <= 1'b0;
			sel_quarter_q <= 1'b0;
			run_q <= 1'b0;
		end else if (boundary) begin
			sel_half_q <= want_half;
			sel_quarter_q <= want_quarter;
			run_q <= want_run;
		end
	end

	// output from a flop so the card sees a clean edge
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n)
			out_q <= 1'b0;
		else if (!run_q)
			out_q <= 1'b0;
		else if (sel_half_q)
			out_q <= ~half_q;
		else if (sel_quarter_q)
			out_q <= (half_q ? ~quarter_q : quarter_q);
		else
			out_q <= 1'b0;
	end

	assign host_half_clock = half_q;
	assign card_clk = out_q;
endmodule : cisc_clkgen

// file: rtl/cisc_top.sv
// supervisor, mode sequencer and control-pin decoding for the card interface
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ps
`include "cisc_consts.svh"
// What this block does
// - logic held in reset below first threshold
// - sequencer blocked until main supply fully up
// - main supply drop starts automatic deactivation
// - card contacts inactive during power transitions
// - alarms and block held until delay good
// - host supply low: alarms, discharge, deactivate
// - host supervisor runs with main supply down
// - crystal clock halved before further division
// - half select low gives half rate
// - quarter select low with half select high gives quarter rate
// - selects sampled so no runt pulses
// - host clock always runs at half rate
// - six modes idle activation read write deact fault
// - fault shown on open-drain active-low interrupt
// - extraction shown on open-drain active-low output
// - two presence inputs, opposite polarities
// - complementary open-drain alarm pair to host
// - activation waits 16 us then 64 us
// - deactivation order reset/clock, io/vpp, vcc
// - fault interrupts, deactivates, releases after request drops
module cisc_top (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic main_above_th1,
	input wire logic main_above_th4,
	input wire logic main_above_th4_hys,
	input wire logic host_supply_ok,
	input wire logic delay_above_th3,
	input wire logic supply_request_n,
	input wire logic clk_half_sel_n,
	input wire logic clk_quarter_sel_n,
	input wire logic host_card_reset_req,
	input wire logic prog_sel_low_n,
	input wire logic prog_sel_mid_n,
	input wire logic prog_sel_high_n,
	input wire logic presence_contact_n,
	input wire logic presence_contact,
	input wire logic overcurrent_fault,
	input wire logic overheat_fault,
	input wire logic [3:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	output logic host_half_clock,
	output logic card_clk,
	output logic card_rst,
	output logic card_vcc_en,
	output logic card_vpp_en,
	output logic [1:0] card_vpp_level,
	output logic card_io_en,
	output logic delay_discharge,
	output logic alarm_hi_out,
	output logic alarm_hi_oe_n,
	output logic alarm_lo_out,
	output logic alarm_lo_oe_n,
	output logic int_out,
	output logic int_oe_n,
	output logic detect_out,
	output logic detect_oe_n
);
	cisc_pkg::cisc_mode_t mode_q;
	cisc_pkg::cisc_mode_t mode_d;
	cisc_pkg::cisc_seq_t seq_q;
	cisc_pkg::cisc_seq_t seq_d;
	logic [`CISC_CNT_W-1:0] cnt_q;
	logic [`CISC_CNT_W-1:0] cnt_d;
	logic fault_q;
	logic fault_d;
	logic [3:0] ctrl_q;
	logic ack_q;
	logic [31:0] rdata_q;
	logic logic_rst_n;
	logic seq_blocked;
	logic alarm;
	logic card_present;
	logic fault_event;
	logic abort;
	logic cnt_done;
	logic prog_req;
	logic rst_en;
	logic wr_ctrl;
	logic rd_ctrl;
	logic rd_stat;
	logic req;

	// cycle count compare shared by every timed step
	function automatic logic reached(input logic [`CISC_CNT_W-1:0] c,
		input integer lim);
		reached = (c >= lim[`CISC_CNT_W-1:0] - 1'b1);
	endfunction : reached

	// combined internal reset; alarm path ignores main supply
	assign logic_rst_n = arst_n & main_above_th1;
	assign alarm = ~host_supply_ok | ~delay_above_th3;
	assign seq_blocked = ~main_above_th4_hys | alarm;
	assign card_present = ~presence_contact_n & presence_contact;
	assign prog_req = ~(prog_sel_low_n & prog_sel_mid_n & prog_sel_high_n);
	// any drop-out or hardware problem aborts an open session
	assign abort = ~main_above_th4 | ~host_supply_ok;
	assign fault_event = (mode_q != cisc_pkg::MODE_IDLE) &
		(abort | overcurrent_fault | overheat_fault | ~card_present);
	assign cnt_done = (mode_q != cisc_pkg::MODE_ACT) ?
		reached(cnt_q, `CISC_CYC_DEACT) :
		(seq_q == cisc_pkg::SEQ_VCC) ?
		reached(cnt_q, `CISC_CYC_VCC_VPP) :
		reached(cnt_q, `CISC_CYC_VPP_CLK);

	// mode and contact sequencer
	always_comb begin
		mode_d = mode_q;
		seq_d = seq_q;
		cnt_d = cnt_q + 1'b1;
		fault_d = fault_q | fault_event;
		case (mode_q)
			cisc_pkg::MODE_IDLE: begin
				cnt_d = '0;
				if (!supply_request_n && !seq_blocked && card_present &&
					!fault_q) begin
					mode_d = cisc_pkg::MODE_ACT;
					seq_d = cisc_pkg::SEQ_VCC;
				end
				if (fault_q && supply_request_n)
					fault_d = 1'b0;
			end
			cisc_pkg::MODE_ACT: begin
				if (cnt_done) begin
					cnt_d = '0;
					if (seq_q == cisc_pkg::SEQ_VCC)
						seq_d = cisc_pkg::SEQ_VPP;
					else begin
						seq_d = cisc_pkg::SEQ_CLK;
						mode_d = cisc_pkg::MODE_READ;
					end
				end
			end
			cisc_pkg::MODE_READ: begin
				cnt_d = '0;
				if (prog_req)
					mode_d = cisc_pkg::MODE_WRITE;
			end
			cisc_pkg::MODE_WRITE: begin
				cnt_d = '0;
				if (!prog_req)
					mode_d = cisc_pkg::MODE_READ;
			end
			cisc_pkg::MODE_DEACT, cisc_pkg::MODE_FAULT: begin
				if (cnt_done) begin
					cnt_d = '0;
					if (seq_q == cisc_pkg::SEQ_D_CLK)
						seq_d = cisc_pkg::SEQ_D_VPP;
					else if (seq_q == cisc_pkg::SEQ_D_VPP)
						seq_d = cisc_pkg::SEQ_VCC;
					else begin
						seq_d = cisc_pkg::SEQ_OFF;
						mode_d = cisc_pkg::MODE_IDLE;
					end
				end
			end
			default: begin
				mode_d = cisc_pkg::MODE_IDLE;
				seq_d = cisc_pkg::SEQ_OFF;
			end
		endcase
		// session end or fault starts the backward count
		if ((mode_q == cisc_pkg::MODE_ACT || mode_q == cisc_pkg::MODE_READ ||
			mode_q == cisc_pkg::MODE_WRITE) &&
			(supply_request_n || fault_event)) begin
			mode_d = fault_event ? cisc_pkg::MODE_FAULT :
				cisc_pkg::MODE_DEACT;
			seq_d = cisc_pkg::SEQ_D_CLK;
			cnt_d = '0;
		end
	end

	// sequencer state; main reset also clears it (power-down safety)
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			mode_q <= cisc_pkg::MODE_IDLE;
			seq_q <= cisc_pkg::SEQ_OFF;
			cnt_q <= '0;
			fault_q <= 1'b0;
		end else if (!logic_rst_n) begin
			mode_q <= cisc_pkg::MODE_IDLE;
			seq_q <= cisc_pkg::SEQ_OFF;
			cnt_q <= '0;
			fault_q <= 1'b0;
		end else begin
			mode_q <= mode_d;
			seq_q <= seq_d;
			cnt_q <= cnt_d;
			fault_q <= fault_d;
		end
	end

	// contact drive decoded from the sequence step; vpp level from the mode and program selects
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			card_vcc_en <= 1'b0;
			card_vpp_en <= 1'b0;
			card_io_en <= 1'b0;
			card_rst <= 1'b0;
			card_vpp_level <= 2'h0;
		end else begin
			card_vcc_en <= logic_rst_n & (seq_q != cisc_pkg::SEQ_OFF);
			card_vpp_en <= logic_rst_n & (seq_q == cisc_pkg::SEQ_VPP ||
				seq_q == cisc_pkg::SEQ_CLK || seq_q == cisc_pkg::SEQ_D_CLK);
			card_io_en <= logic_rst_n & (seq_q == cisc_pkg::SEQ_CLK ||
				seq_q == cisc_pkg::SEQ_D_CLK);
			card_rst <= rst_en & host_card_reset_req;
			card_vpp_level <= (mode_q != cisc_pkg::MODE_WRITE) ? 2'h0 :
				!prog_sel_high_n ? 2'h3 : !prog_sel_mid_n ? 2'h2 : 2'h1;
		end
	end

	assign rst_en = logic_rst_n & (seq_q == cisc_pkg::SEQ_CLK) &
		~ctrl_q[0];

	cisc_clkgen u_clk (
		.sys_clk(sys_clk),
		.arst_n(arst_n),
		.clk_half_sel_n(clk_half_sel_n),
		.clk_quarter_sel_n(clk_quarter_sel_n),
		.internal_reset_enable(rst_en),
		.host_half_clock(host_half_clock),
		.card_clk(card_clk)
	);

	// open-drain pins: enable low pulls the line low
	assign delay_discharge = ~host_supply_ok;
	assign alarm_lo_out = 1'b0;
	assign alarm_lo_oe_n = ~alarm;
	assign alarm_hi_out = 1'b0;
	assign alarm_hi_oe_n = alarm;
	assign int_out = 1'b0;
	assign int_oe_n = ~fault_q;
	assign detect_out = 1'b0;
	assign detect_oe_n = card_present;

	// register decode; one wait cycle on every access
	assign req = (avs_read | avs_write) & ~ack_q;
	assign wr_ctrl = avs_write & ack_q & (avs_address == `CISC_ADDR_CTRL);
	assign rd_ctrl = avs_address == `CISC_ADDR_CTRL;
	assign rd_stat = avs_address == `CISC_ADDR_STAT;
	assign avs_waitrequest = (avs_read | avs_write) & ~ack_q;
	assign avs_readdata = rdata_q;

	// bus slave; status word shows live mode and supervisor state
	always_ff @(posedge sys_clk or negedge arst_n) begin
		if (!arst_n) begin
			ack_q <= 1'b0;
			ctrl_q <= `CISC_CTRL_RST;
			rdata_q <= 32'h0000_0000;
		end else begin
			ack_q <= req;
			if (wr_ctrl)
				ctrl_q <= avs_writedata[3:0];
			if (req && avs_read) begin
				if (rd_ctrl)
					rdata_q <= {28'h000_0000, ctrl_q};
				else if (rd_stat)
					rdata_q <= {20'h0_0000, card_present, fault_q, alarm,
						seq_blocked, 1'b0, seq_q, 1'b0, mode_q};
				else
					rdata_q <= `CISC_BAD_DATA;
			end
		end
	end
endmodule : cisc_top

// file: verification/cisc_checker.sv
// timing checks on the card interface supervisor ports
`timescale 1ns/1ps
module cisc_checker (
	input wire logic sys_clk,
	input wire logic arst_n,
	input wire logic main_above_th1,
	input wire logic main_above_th4_hys,
	input wire logic host_supply_ok,
	input wire logic delay_above_th3,
	input wire logic clk_half_sel_n,
	input wire logic clk_quarter_sel_n,
	input wire logic overcurrent_fault,
	input wire logic presence_contact_n,
	input wire logic presence_contact,
	input wire logic host_half_clock,
	input wire logic card_clk,
	input wire logic card_rst,
	input wire logic card_vcc_en,
	input wire logic card_vpp_en,
	input wire logic card_io_en,
	input wire logic delay_discharge,
	input wire logic alarm_lo_oe_n,
	input wire logic alarm_hi_oe_n,
	input wire logic int_oe_n,
	input wire logic detect_oe_n
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!arst_n);
	// two cycles allow for the sync reset to land
	AST_RESET_HOLD: assert property (
		!main_above_th1 [*2] |-> !card_vcc_en && !card_vpp_en)
		else $error("contacts live in reset");
	AST_SEQ_BLOCK: assert property (
		!main_above_th4_hys && !card_vcc_en |=> !card_vcc_en)
		else $error("supply rose while blocked");
	AST_ALARM_HOLD: assert property (
		!delay_above_th3 [*3] |-> !alarm_lo_oe_n)
		else $error("alarm released early");
	AST_DISCHARGE: assert property (
		!host_supply_ok |-> delay_discharge)
		else $error("delay node not discharged");
	// the edge that releases reset has no toggle behind it yet
	AST_HOST_CLK: assert property (
		arst_n |=> host_half_clock != $past(host_half_clock))
		else $error("host clock stalled");
	// a ratio change waits up to four cycles for both dividers high
	AST_CLK_IDLE: assert property (
		(clk_half_sel_n && clk_quarter_sel_n) [*6] |-> !card_clk)
		else $error("card clock not low");
	AST_FAULT_INT: assert property (
		overcurrent_fault && card_vcc_en |-> ##[1:3] !int_oe_n)
		else $error("fault not signalled");
	AST_DETECT: assert property (
		(presence_contact_n || !presence_contact) [*3] |-> !detect_oe_n)
		else $error("absence not shown");
	// pair must be complementary and follow the supervisor inputs
	AST_ALARM_PAIR: assert property (
		alarm_lo_oe_n != alarm_hi_oe_n &&
		alarm_lo_oe_n == (host_supply_ok && delay_above_th3))
		else $error("alarm pair wrong");
	AST_DEACT_ORDER: assert property (
		$fell(card_vcc_en) |->
		!card_rst && !card_clk && !card_vpp_en && !card_io_en)
		else $error("supply dropped too soon");
	AST_VPP_AFTER_VCC: assert property (
		$rose(card_vpp_en) |-> card_vcc_en)
		else $error("vpp before vcc");
endmodule : cisc_checker

bind cisc_top cisc_checker cisc_checker_inst (.*);

// file: verification/cisc_host_model.sv
// host side pins and pulled-up open-drain lines
`timescale 1ns/1ps
module cisc_host_model (
	input wire logic want_power,
	input wire logic want_reset,
	input wire logic [1:0] level,
	input wire logic int_out,
	input wire logic int_oe_n,
	input wire logic detect_out,
	input wire logic detect_oe_n,
	output logic supply_request_n,
	output logic prog_sel_low_n,
	output logic prog_sel_mid_n,
	output logic prog_sel_high_n,
	output logic host_card_reset_req,
	output logic int_line,
	output logic detect_line
);
	// request pins, all low-true except card reset
	assign supply_request_n = !want_power;
	assign prog_sel_low_n = !(level == 2'h1);
	assign prog_sel_mid_n = !(level == 2'h2);
	assign prog_sel_high_n = !(level == 2'h3);
	assign host_card_reset_req = want_reset;
	// pull-ups win whenever the block lets go
	assign int_line = int_oe_n ? 1'b1 : int_out;
	assign detect_line = detect_oe_n ? 1'b1 : detect_out;
endmodule : cisc_host_model

// file: verification/card_interface_supervisor_clock_tb.sv
// self-checking bench for the card interface supervisor
`timescale 1ns/1ps
`include "cisc_consts.svh"
module card_interface_supervisor_clock_tb;
	logic sys_clk, arst_n, main_above_th1, main_above_th4, main_above_th4_hys;
	logic host_supply_ok, delay_above_th3, supply_request_n, clk_half_sel_n;
	logic clk_quarter_sel_n, host_card_reset_req, prog_sel_low_n;
	logic prog_sel_mid_n, prog_sel_high_n, presence_contact_n;
	logic presence_contact, overcurrent_fault, overheat_fault;
	logic [3:0] avs_address;
	logic avs_read, avs_write, avs_waitrequest;
	logic [31:0] avs_writedata, avs_readdata, rd;
	logic host_half_clock, card_clk, card_rst, card_vcc_en, card_vpp_en;
	logic [1:0] card_vpp_level, level;
	logic card_io_en, delay_discharge, alarm_hi_out, alarm_hi_oe_n;
	logic alarm_lo_out, alarm_lo_oe_n, int_out, int_oe_n, detect_out;
	logic detect_oe_n, want_power, want_reset, int_line, detect_line;
	int err_total, num_checks, n;

	cisc_top cisc_top_inst (.*);
	cisc_host_model cisc_host_model_inst (.*);

	initial begin
		sys_clk = 1'b0;
		forever #25 sys_clk = ~sys_clk;
	end

	task automatic chk(input string nm, input logic [31:0] got, exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("wrong value %s exp %h got %h", nm, exp, got);
		end
	endtask : chk

	// holds the request until waitrequest is seen low at an edge
	task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
		int k = 0;
		avs_address <= a;
		avs_writedata <= wd;
		avs_read <= !wr;
		avs_write <= wr;
		do begin
			@(posedge sys_clk);
			k++;
		end while (avs_waitrequest !== 1'b0 && k < 50);
		rd = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge sys_clk);
		if (k == 50) chk("bus timeout", 0, 1);
	endtask : bus

	function automatic logic pick(input int k);
		case (k)
			0: pick = card_vcc_en;
			1: pick = card_vpp_en;
			default: pick = card_clk;
		endcase
	endfunction : pick

	// bounded wait, n is cycles spent
	task automatic wait_for(input int k, input logic v);
		n = 0;
		while (pick(k) !== v && n < 4000) begin
			@(posedge sys_clk);
			n++;
		end
		if (n == 4000) chk("wait timeout", 0, 1);
	endtask : wait_for

	// rising card clock edges seen over 40 system cycles
	task automatic count_clk(input logic [31:0] exp, input string nm);
		logic prev = card_clk;
		int r = 0;
		repeat (40) begin
			@(posedge sys_clk);
			if (card_clk === 1'b1 && prev === 1'b0) r++;
			prev = card_clk;
		end
		chk(nm, r, exp);
	endtask : count_clk

	task automatic summarize;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : summarize

	initial begin
		repeat (40000) @(posedge sys_clk);
		err_total++;
		summarize();
	end

	initial begin
		{arst_n, avs_read, avs_write, overcurrent_fault, overheat_fault} = '0;
		{main_above_th1, main_above_th4, main_above_th4_hys} = 3'h7;
		{host_supply_ok, delay_above_th3, presence_contact} = 3'h7;
		{clk_half_sel_n, clk_quarter_sel_n, presence_contact_n} = 3'h6;
		{want_power, want_reset, level} = 4'h0;
		avs_address = 4'h0;
		avs_writedata = 32'h0;
		repeat (16) @(posedge sys_clk);
		arst_n <= 1'b1;
		@(posedge sys_clk);
		bus(1'b0, `CISC_ADDR_STAT, 32'h0);
		chk("idle mode", rd[2:0], cisc_pkg::MODE_IDLE);
		chk("present", rd[11], 1'b1);
		bus(1'b0, 4'h8, 32'h0);
		chk("unmapped", rd, `CISC_BAD_DATA);
		bus(1'b0, `CISC_ADDR_CTRL, 32'h0);
		chk("ctrl reset", rd, `CISC_CTRL_RST);
		// each presence input alone must show absence
		presence_contact <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("detect hi", detect_line, 1'b0);
		{presence_contact, presence_contact_n} <= 2'h3;
		repeat (4) @(posedge sys_clk);
		chk("detect lo", detect_line, 1'b0);
		presence_contact_n <= 1'b0;
		clk_half_sel_n <= 1'b0;
		want_power <= 1'b1;
		wait_for(0, 1'b1);
		wait_for(1, 1'b1);
		chk("vcc to vpp", n, `CISC_CYC_VCC_VPP);
		wait_for(2, 1'b1);
		count_clk(20, "half rate");
		bus(1'b0, `CISC_ADDR_STAT, 32'h0);
		chk("read mode", rd[2:0], cisc_pkg::MODE_READ);
		{clk_half_sel_n, clk_quarter_sel_n} <= 2'h2;
		want_reset <= 1'b1;
		repeat (8) @(posedge sys_clk);
		chk("card reset", card_rst, 1'b1);
		chk("io on", card_io_en, 1'b1);
		count_clk(10, "quarter rate");
		level <= 2'h3;
		repeat (4) @(posedge sys_clk);
		chk("vpp level", card_vpp_level, 2'h3);
		bus(1'b1, `CISC_ADDR_CTRL, 32'h1);
		repeat (8) @(posedge sys_clk);
		count_clk(0, "clock off");
		chk("reset gated", card_rst, 1'b0);
		bus(1'b1, `CISC_ADDR_CTRL, 32'h0);
		repeat (8) @(posedge sys_clk);
		count_clk(10, "clock back");
		// both selects high must stop a running clock
		{clk_half_sel_n, clk_quarter_sel_n} <= 2'h3;
		repeat (8) @(posedge sys_clk);
		count_clk(0, "no select");
		{want_power, want_reset, level} <= 4'h0;
		wait_for(0, 1'b0);
		bus(1'b0, `CISC_ADDR_STAT, 32'h0);
		chk("back idle", rd[2:0], cisc_pkg::MODE_IDLE);
		// fault must outlast deactivation until request drops
		want_power <= 1'b1;
		wait_for(0, 1'b1);
		overcurrent_fault <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("int low", int_line, 1'b0);
		overcurrent_fault <= 1'b0;
		wait_for(0, 1'b0);
		chk("int held", int_line, 1'b0);
		want_power <= 1'b0;
		repeat (8) @(posedge sys_clk);
		chk("int freed", int_line, 1'b1);
		want_power <= 1'b1;
		wait_for(1, 1'b1);
		{main_above_th4, main_above_th4_hys} <= 2'h0;
		wait_for(0, 1'b0);
		chk("main drop", n < 4000, 1'b1);
		// fault clears, then the first threshold drops mid-session
		want_power <= 1'b0;
		{main_above_th4, main_above_th4_hys} <= 2'h3;
		repeat (4) @(posedge sys_clk);
		want_power <= 1'b1;
		wait_for(0, 1'b1);
		main_above_th1 <= 1'b0;
		repeat (4) @(posedge sys_clk);
		chk("th1 reset", card_vcc_en, 1'b0);
		want_power <= 1'b0;
		main_above_th1 <= 1'b1;
		{host_supply_ok, delay_above_th3} <= 2'h0;
		repeat (3) @(posedge sys_clk);
		chk("discharge", delay_discharge, 1'b1);
		host_supply_ok <= 1'b1;
		repeat (20) @(posedge sys_clk);
		chk("alarm held", alarm_lo_oe_n, 1'b0);
		chk("alarm hi", alarm_hi_oe_n, 1'b1);
		delay_above_th3 <= 1'b1;
		repeat (4) @(posedge sys_clk);
		chk("alarm off", alarm_lo_oe_n, 1'b1);
		summarize();
	end
endmodule : card_interface_supervisor_clock_tb
